// File: shared/clk_sel_defs.svh
`ifndef CLK_SEL_DEFS_SVH
`define CLK_SEL_DEFS_SVH

// register byte offsets
`define GATE_OFS       12'h040
`define SRC_OFS        12'h054

// reset values and writable-bit masks
`define GATE_RST       32'h0000_0001
`define GATE_MASK      32'h00F7_DE01
`define SRC_RST        32'h0000_0000
`define SRC_MASK       32'h000C_07C0

// gate register bit positions
`define DISPLAY_BIT    23
`define SYSCFG_BIT     0

// source register field positions
`define LPT_HI         19
`define LPT_LO         18
`define CMP3_BIT       10
`define CMP2_BIT       9
`define CMP1_BIT       8
`define VMON_BIT       7
`define CAN_BIT        6

// low-power timer source codes
`define LPT_BUS        2'h0
`define LPT_LSI        2'h1
`define LPT_NONE       2'h2
`define LPT_LSE        2'h3

`endif

// File: shared/clk_sel_pkg.sv
`default_nettype none
package clk_sel_pkg;

  // apb request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  // apb answer to the master
  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } apb_rsp_t;

  // gated bus clocks, one per module
  typedef struct packed {
    logic display;
    logic comparator3;
    logic comparator2;
    logic comparator1;
    logic timer17;
    logic timer16;
    logic timer15;
    logic timer14;
    logic serialPort1;
    logic syncSerial1;
    logic advancedTimer;
    logic debugUnit;
    logic converter;
    logic systemConfig;
  } gate_clk_t;

  // selected kernel clocks
  typedef struct packed {
    logic lowPowerTimer;
    logic comparator1;
    logic comparator2;
    logic comparator3;
    logic voltageMonitor;
    logic canKernel;
  } kernel_clk_t;

  // whole rising-edge bus-clock state of the block
  typedef struct packed {
    logic [31:0] gate;
    logic [31:0] src;
    logic [31:0] rdata;
    logic        err;
    logic        ansReady;
    logic        wroteGate;
  } state_t;

endpackage
`default_nettype wire

// File: design/peripheral_clock_gate_select.sv
`include "clk_sel_defs.svh"
`default_nettype none
module peripheral_clock_gate_select
  import clk_sel_pkg::*;
(
  // clock, reset, enable
  input  wire logic  clk,
  input  wire logic  arst_n,
  input  wire logic  ce,
  // register bus
  input  wire apb_req_t apbReq,
  output apb_rsp_t      apbRsp,
  // kernel clock sources
  input  wire logic  internalLowSpeedOsc,
  input  wire logic  externalLowSpeedOsc,
  input  wire logic  selectedLowSpeedClk,
  input  wire logic  pllClk,
  input  wire logic  externalHighSpeedOsc,
  // delivered clocks
  output gate_clk_t   gateClk,
  output kernel_clk_t kernelClk
);

  localparam int NGATE = 14;
  localparam int NLEG  = 13;
  localparam int NCH   = 6;
  // channel of each switch leg, leg 0 first
  localparam int LEG_CH [NLEG] = '{0, 0, 0, 1, 1, 2, 2, 3, 3, 4, 4, 5, 5};

  state_t             st_q;
  state_t             st_d;
  logic               done;
  logic [NGATE-1:0]   gateBits;
  logic [NGATE-1:0]   gateLat_q;
  logic [NLEG-1:0]    legClk;
  logic [NLEG-1:0]    legWant;
  logic [NLEG-1:0]    legEn;
  logic [NCH-1:0]     chanClk;

  // register select: bit 1 gate, bit 0 source
  function automatic logic [1:0] decode(input logic [11:0] a);
    decode = {a == `GATE_OFS, a == `SRC_OFS};
  endfunction

  // legs that share a channel with leg l
  function automatic logic [NLEG-1:0] peerMask(input int l);
    logic [NLEG-1:0] m;
    m = '0;
    for (int k = 0; k < NLEG; k++) begin
      m[k] = (LEG_CH[k] == LEG_CH[l]) && (k != l);
    end
    return m;
  endfunction

  // legs belonging to channel c
  function automatic logic [NLEG-1:0] chanMask(input int c);
    logic [NLEG-1:0] m;
    m = '0;
    for (int k = 0; k < NLEG; k++) begin
      m[k] = (LEG_CH[k] == c);
    end
    return m;
  endfunction

  // transfer completes in the access phase once data is staged
  assign done = apbReq.psel & apbReq.penable & ce & st_q.ansReady;

  // bus answer: ready combinational, data from flops
  always_comb begin
    apbRsp.pready  = apbReq.psel & apbReq.penable & ce & st_q.ansReady;
    apbRsp.prdata  = st_q.rdata;
    apbRsp.pslverr = st_q.err;
  end

  // next-state of registers and bus staging
  always_comb begin
    logic [1:0] sel;
    sel  = decode(apbReq.paddr);
    st_d = st_q;
    if (ce) begin
      if (apbReq.psel && !st_q.ansReady) begin
        // stage read data and error before the access edge
        st_d.ansReady = 1'b1;
        st_d.err      = ~|sel;
        st_d.rdata    = ({32{sel[1]}} & st_q.gate)
                      | ({32{sel[0]}} & st_q.src);
      end
      if (done) begin
        st_d.ansReady = 1'b0;
        if (apbReq.pwrite && sel[1]) begin
          st_d.gate      = apbReq.pwdata & `GATE_MASK;
          st_d.wroteGate = 1'b1;
        end
        if (apbReq.pwrite && sel[0]) begin
          st_d.src = apbReq.pwdata & `SRC_MASK;
        end
      end
    end
  end

  // state register, reset values of both registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '{gate: `GATE_RST, src: `SRC_RST, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  // per-module gate bits in output order
  assign gateBits = {st_q.gate[23:20], st_q.gate[18:14],
                     st_q.gate[12:9], st_q.gate[`SYSCFG_BIT]};

  // enables change only while the bus clock is low
  always_ff @(negedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gateLat_q <= NGATE'(`GATE_RST);
    end else if (ce) begin
      gateLat_q <= gateBits;
    end
  end

  // gated bus clocks, glitch free since enable is steady in high phase
  assign gateClk = gate_clk_t'({NGATE{clk}} & gateLat_q);

  // clock of each leg
  assign legClk = {externalHighSpeedOsc, pllClk,
                   selectedLowSpeedClk, clk,
                   selectedLowSpeedClk, clk,
                   selectedLowSpeedClk, clk,
                   selectedLowSpeedClk, clk,
                   externalLowSpeedOsc, internalLowSpeedOsc, clk};

  // which leg each channel asks for
  always_comb begin
    legWant     = '0;
    legWant[0]  = st_q.src[`LPT_HI:`LPT_LO] == `LPT_BUS;
    legWant[1]  = st_q.src[`LPT_HI:`LPT_LO] == `LPT_LSI;
    legWant[2]  = st_q.src[`LPT_HI:`LPT_LO] == `LPT_LSE;
    legWant[3]  = ~st_q.src[`CMP1_BIT];
    legWant[4]  = st_q.src[`CMP1_BIT];
    legWant[5]  = ~st_q.src[`CMP2_BIT];
    legWant[6]  = st_q.src[`CMP2_BIT];
    legWant[7]  = ~st_q.src[`CMP3_BIT];
    legWant[8]  = st_q.src[`CMP3_BIT];
    legWant[9]  = ~st_q.src[`VMON_BIT];
    legWant[10] = st_q.src[`VMON_BIT];
    legWant[11] = ~st_q.src[`CAN_BIT];
    legWant[12] = st_q.src[`CAN_BIT];
  end

  // each leg syncs its enable on its own falling edge,
  // and waits until every peer leg has let go first
  for (genvar l = 0; l < NLEG; l++) begin : g_leg
    logic sync1_q;
    logic en_q;
    always_ff @(negedge legClk[l] or negedge arst_n) begin
      if (!arst_n) begin
        sync1_q <= 1'b0;
        en_q    <= 1'b0;
      end else begin
        sync1_q <= legWant[l] & ~|(legEn & peerMask(l));
        en_q    <= sync1_q;
      end
    end
    assign legEn[l] = en_q;
  end

  // channel clock is the one enabled leg, or none
  for (genvar c = 0; c < NCH; c++) begin : g_chan
    assign chanClk[c] = |(legClk & legEn & chanMask(c));
  end

  // kernel outputs by name, channel 0 is the low-power timer
  always_comb begin
    kernelClk.lowPowerTimer  = chanClk[0];
    kernelClk.comparator1    = chanClk[1];
    kernelClk.comparator2    = chanClk[2];
    kernelClk.comparator3    = chanClk[3];
    kernelClk.voltageMonitor = chanClk[4];
    kernelClk.canKernel      = chanClk[5];
  end

  // ----- checks -----
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  logic [1:0] setupSel;
  logic       setupRd;
  assign setupSel = decode(apbReq.paddr);
  assign setupRd  = apbReq.psel & ~apbReq.penable & ~apbReq.pwrite & ce
                  & ~st_q.ansReady;

  a_gate_write_mask:
  assert property (done && apbReq.pwrite && setupSel[1]
                   |=> st_q.gate == ($past(apbReq.pwdata) & `GATE_MASK))
  else $error("gate register write not stored as masked");

  a_gate_reset_val:
  assert property (!st_q.wroteGate |-> st_q.gate == `GATE_RST)
  else $error("gate register left reset value without a write");

  a_sysconfig_stop:
  assert property (done && apbReq.pwrite && setupSel[1]
                   && !apbReq.pwdata[`SYSCFG_BIT]
                   |=> ##1 !gateLat_q[0])
  else $error("system config clock did not stop");

  a_gate_latch_track:
  assert property (gateLat_q == gateBits)
  else $error("gate enables differ from gate register");

  a_display_follows:
  assert property ($rose(st_q.gate[`DISPLAY_BIT])
                   |=> gateLat_q[NGATE-1] ##1 gateLat_q[NGATE-1])
  else $error("display clock gate did not open");

  a_reserved_zero:
  assert property (((st_q.gate & ~`GATE_MASK) == '0)
                   && ((st_q.src & ~`SRC_MASK) == '0))
  else $error("reserved bit holds a one");

  a_read_gate:
  assert property (setupRd && setupSel[1]
                   |=> apbRsp.prdata == st_q.gate && !apbRsp.pslverr)
  else $error("gate register read returned wrong data");

  a_read_src:
  assert property (setupRd && setupSel[0]
                   |=> apbRsp.prdata == st_q.src && !apbRsp.pslverr)
  else $error("source register read returned wrong data");

  a_unmapped_err:
  assert property (setupRd && setupSel == 2'b00
                   |=> apbRsp.pslverr && apbRsp.prdata == '0)
  else $error("unmapped read not flagged");

  a_timer_bus_off:
  assert property ((st_q.src[`LPT_HI:`LPT_LO] != `LPT_BUS) [*2]
                   |-> !legEn[0])
  else $error("timer kept bus clock after deselect");

  a_timer_bus_on:
  assert property ((st_q.src[`LPT_HI:`LPT_LO] == `LPT_BUS
                    && legEn[2:1] == 2'b00) [*3]
                   |-> legEn[0])
  else $error("timer did not take bus clock");

  a_comp1_bus_off:
  assert property (st_q.src[`CMP1_BIT] [*2] |-> !legEn[3])
  else $error("comparator one kept bus clock");

  a_comp2_bus_off:
  assert property (st_q.src[`CMP2_BIT] [*2] |-> !legEn[5])
  else $error("comparator two kept bus clock");

  a_comp3_bus_off:
  assert property (st_q.src[`CMP3_BIT] [*2] |-> !legEn[7])
  else $error("comparator three kept bus clock");

  a_vmon_bus_off:
  assert property (st_q.src[`VMON_BIT] [*2] |-> !legEn[9])
  else $error("voltage monitor kept bus clock");

  a_can_exclusive:
  assert property ($onehot0(legEn[12:11]) && $onehot0(legEn[2:0]))
  else $error("two sources enabled on one channel");

  a_sysconfig_start:
  assert property (done && apbReq.pwrite && setupSel[1]
                   && apbReq.pwdata[`SYSCFG_BIT] |=> ##1 gateLat_q[0])
  else $error("system config clock did not start");

  a_comp3_gate:
  assert property (gateLat_q[12] == st_q.gate[22])
  else $error("comparator three gate differs from its bit");

  a_comp_gates:
  assert property (gateLat_q[11:10] == st_q.gate[21:20])
  else $error("comparator gates differ from their bits");

  a_timer_gates:
  assert property (gateLat_q[9:6] == st_q.gate[18:15])
  else $error("timer gates differ from their bits");

  a_serial_gate:
  assert property (gateLat_q[5] == st_q.gate[14])
  else $error("serial port gate differs from its bit");

  a_sync_serial_gate:
  assert property (gateLat_q[4] == st_q.gate[12])
  else $error("synchronous serial gate differs from its bit");

  a_adv_timer_gate:
  assert property (gateLat_q[3] == st_q.gate[11])
  else $error("advanced timer gate differs from its bit");

  a_comp1_bus_on:
  assert property ((!st_q.src[`CMP1_BIT] && !legEn[4]) [*3] |-> legEn[3])
  else $error("comparator one did not take bus clock");

  a_vmon_bus_on:
  assert property ((!st_q.src[`VMON_BIT] && !legEn[10]) [*3] |-> legEn[9])
  else $error("voltage monitor did not take bus clock");

  a_src_write_mask:
  assert property (done && apbReq.pwrite && setupSel[0]
                   |=> st_q.src == ($past(apbReq.pwdata) & `SRC_MASK))
  else $error("source register write not stored as masked");

  a_ready_zero_wait:
  assert property (apbReq.psel && !apbReq.penable && ce && !st_q.ansReady
                   ##1 apbReq.psel && apbReq.penable && ce
                   |-> apbRsp.pready)
  else $error("access phase not answered at once");

endmodule
`default_nettype wire

// File: dv/tb_top.sv
`default_nettype none
module tb_top
  import clk_sel_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // register row: address, write word, read-back, error
  typedef struct {
    logic [11:0] a;
    logic [31:0] w;
    logic [31:0] r;
    logic        e;
  } row_t;
  // source row: word, expected leg per kernel output (msb first)
  typedef struct {
    logic [31:0] w;
    int          leg [6];
  } krow_t;

  logic        clk, arstN, ce;
  logic        lsInt, lsExt, lsSel, pll, hsExt;
  apb_req_t    req;
  apb_rsp_t    rsp;
  gate_clk_t   gClk;
  kernel_clk_t kClk;
  int          failures, totalChecks;

  row_t rows [5] = '{
    '{12'h040, 32'hFFFF_FFFF, 32'h00F7_DE01, 1'h0},
    '{12'h040, 32'h0000_0000, 32'h0000_0000, 1'h0},
    '{12'h054, 32'hFFFF_FFFF, 32'h000C_07C0, 1'h0},
    '{12'h054, 32'h0000_0000, 32'h0000_0000, 1'h0},
    '{12'h044, 32'hFFFF_FFFF, 32'h0000_0000, 1'h1}};
  int pos [14] = '{0, 9, 10, 11, 12, 14, 15, 16, 17, 18, 20, 21, 22, 23};
  // legs: 0 bus, 1 int low, 2 none, 3 ext low, 4 sel low, 5 pll, 6 ext fast
  krow_t krows [4] = '{
    '{32'h0000_0000, '{0, 0, 0, 0, 0, 5}},
    '{32'h0004_0140, '{1, 4, 0, 0, 0, 6}},
    '{32'h0008_0280, '{2, 0, 4, 0, 4, 5}},
    '{32'h000C_0400, '{3, 0, 0, 4, 0, 5}}};

  peripheral_clock_gate_select uut (
    .clk(clk), .arst_n(arstN), .ce(ce), .apbReq(req), .apbRsp(rsp),
    .internalLowSpeedOsc(lsInt), .externalLowSpeedOsc(lsExt),
    .selectedLowSpeedClk(lsSel), .pllClk(pll),
    .externalHighSpeedOsc(hsExt), .gateClk(gClk), .kernelClk(kClk));

  // bus clock
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  // source clocks, edges kept off the sampling instants
  initial begin
    lsInt = 1'h0;
    lsExt = 1'h0;
    lsSel = 1'h0;
    pll = 1'h0;
    hsExt = 1'h0;
    fork
      #11 forever #200 lsInt = ~lsInt;
      #7 forever #150 lsExt = ~lsExt;
      #9 forever #130 lsSel = ~lsSel;
      #3 forever #35 pll = ~pll;
      #1 forever #45 hsExt = ~hsExt;
    join
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    totalChecks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t %s: got %h exp %h", $time, m, got, exp);
    end
  endtask

  // one apb transfer, left in access so the next may follow at once
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd, input logic [31:0] ex,
                      input logic er, input string m);
    int n;
    req.psel <= 1'h1;
    req.penable <= 1'h0;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= wd;
    @(posedge clk);
    req.penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'h1 && n < 100);
    if (n >= 100)
      chk(32'h0, 32'h1, "no pready");
    if (!wr)
      chk(rsp.prdata, ex, m);
    chk({31'h0, rsp.pslverr}, {31'h0, er}, m);
  endtask

  task automatic idle();
    req.psel <= 1'h0;
    req.penable <= 1'h0;
  endtask

  // gated clocks high only where enabled, low in the low phase
  task automatic gchk(input logic [13:0] exp, input string m);
    @(posedge clk);
    #12 chk({18'h0, gClk}, {18'h0, exp}, m);
    #25 chk({18'h0, gClk}, 32'h0, m);
  endtask

  function automatic logic leg(input int s);
    case (s)
      0: leg = clk;
      1: leg = lsInt;
      2: leg = 1'h0;
      3: leg = lsExt;
      4: leg = lsSel;
      5: leg = pll;
      default: leg = hsExt;
    endcase
  endfunction

  task automatic kchk(input int r);
    for (int j = 0; j < 6; j++)
      chk({31'h0, kClk[5 - j]}, {31'h0, leg(krows[r].leg[j])}, "kernel");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // watchdog, far beyond the expected run length
  initial begin
    #(50 * 3000);
    failures++;
    end_of_test();
  end

  // main sequence
  initial begin
    failures = 0;
    totalChecks = 0;
    arstN = 1'h0;
    ce = 1'h1;
    req = '0;
    repeat (20) @(posedge clk);
    gchk(14'h0001, "gate in reset");
    arstN <= 1'h1;
    @(posedge clk);
    xfer(0, 12'h040, 0, 32'h1, 0, "gate reset");
    xfer(0, 12'h054, 0, 32'h0, 0, "src reset");
    foreach (rows[i]) begin
      xfer(1, rows[i].a, rows[i].w, 0, rows[i].e, "write");
      xfer(0, rows[i].a, 0, rows[i].r, rows[i].e, "read");
    end
    xfer(0, 12'h040, 0, 32'h0, 0, "unmapped kept");
    for (int i = 0; i < 14; i++) begin
      xfer(1, 12'h040, (32'h1 << pos[i]) | 32'hFF08_21FE, 0, 0, "gw");
      idle();
      gchk(14'h1 << i, "gate bit");
    end
    foreach (krows[r]) begin
      xfer(1, 12'h054, krows[r].w, 0, 0, "src write");
      idle();
      repeat (60) @(posedge clk);
      repeat (8) begin
        @(posedge clk);
        #12 kchk(r);
        #25 kchk(r);
      end
    end
    // frozen bus: no answer until enable returns
    fork
      xfer(0, 12'h040, 0, 32'h0080_0000, 0, "frozen read");
      begin
        ce <= 1'h0;
        repeat (4) @(negedge clk) chk({31'h0, rsp.pready}, 32'h0, "ce");
        @(posedge clk) ce <= 1'h1;
      end
    join
    idle();
    arstN <= 1'h0;
    repeat (20) @(posedge clk);
    arstN <= 1'h1;
    @(posedge clk);
    xfer(0, 12'h040, 0, 32'h1, 0, "gate rereset");
    xfer(0, 12'h054, 0, 32'h0, 0, "src rereset");
    idle();
    @(posedge clk);
    end_of_test();
  end
endmodule
`default_nettype wire
